/* logic/lcc_regs.sv */
// Purpose: APB register bank for the channel A and B configuration registers.
// Assumes: Global, control and status registers live elsewhere on clk_sys.
// Notes: Effective controls and the multifunction pins are registered.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: Bits 15:12 read zero, writes dropped.
// RULE_02: Clock compensation ORed with global bit 11.
// RULE_03: Bits 10:9 pick multifunction pin source.
// RULE_04: Channel A uses status bits 0, 4.
// RULE_05: Channel B uses status bits 1, 5.
// RULE_06: Pin selector ORed with global bits 10:9.
// RULE_07: Signal-missing detect ANDed with global bit 8.
// RULE_08: Bit 7 ORed global; locked while pin high.
// RULE_09: Bit 6 ORed global; locked while pin high.
// RULE_10: Emphasis bits 5:4 ORed with global.
// RULE_11: Loopback ORed with control bit 14.
// RULE_12: Channel A loopback locked while pin high.
// RULE_13: Pattern test ORed global; locked by pin.
// RULE_14: Comma detect ANDed with pin and global.
// RULE_15: Power-down ORed with control bit 11.
// RULE_16: Channel B register independent, same layout.
// RULE_17: Global write overwrites channel settings.
// RULE_18: Effective values drive controls and pins.
module lcc_regs
  import lcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Global configuration register and its write strobe.
  input wire logic [15:0] global_cfg,
  input wire logic global_write,
  // Control register 0 loopback and power-down bits.
  input wire logic ctrl_loopback,
  input wire logic ctrl_power_down,
  // Status register 22 and per-channel comma detect flags.
  input wire logic [7:0] status_22,
  input wire logic [1:0] comma_detected,
  // External pins.
  input wire logic lane_a_loopback_pin,
  input wire logic pattern_test_pin,
  input wire logic comma_align_pin,
  input wire logic setup_select_low_pin,
  input wire logic setup_select_high_pin,
  input wire logic io_standard_pin,
  // Multifunction output pins.
  output logic lane_a_multi_out_pin,
  output logic lane_b_multi_out_pin,
  // Effective channel controls, register bit positions.
  output logic [11:0] lane_a_controls,
  output logic [11:0] lane_b_controls
);

  // Whole state of the bank in one record.
  typedef struct packed {
    logic [SYN_WIDTH-1:0] sync1;
    logic [SYN_WIDTH-1:0] sync2;
    logic [1:0][15:0] chan;
    logic [15:0] rdata;
    logic [1:0] mf;
    logic [1:0][11:0] eff;
  } lcc_state_type;

  // Registered state.
  lcc_state_type s;
  // Next state built by the combinational process.
  lcc_state_type next_s;
  // Raw pin levels gathered into the synchroniser order.
  logic [SYN_WIDTH-1:0] pin_raw;
  // Address hit per channel register.
  logic [1:0] hit;
  // Bits a write may change in each channel this cycle.
  logic [1:0][15:0] wmask;
  // Effective controls from the combining modules.
  logic [1:0][11:0] mix_eff;
  // Transfer phases.
  logic setup_phase;
  logic access_write;

  // Pin order matches the synchroniser positions.
  assign pin_raw = {io_standard_pin, setup_select_high_pin, setup_select_low_pin,
                    comma_align_pin, pattern_test_pin, lane_a_loopback_pin};

  // Word-aligned address decode.
  assign hit[0] = (paddr == ADDR_CHAN_A);
  assign hit[1] = (paddr == ADDR_CHAN_B);

  // Setup cycle latches read data; access cycle commits writes.
  assign setup_phase = psel & ~penable;
  assign access_write = psel & penable & pwrite;

  // The bank never stretches a transfer.
  assign pready = 1'b1;

  // Unmapped addresses answer with an error in the access cycle.
  assign pslverr = psel & penable & ~(|hit);

  // Read data comes from the latched word; upper half reads zero.
  assign prdata = {16'h0000, s.rdata};

  // Controls and pins come straight from flip-flops.
  assign lane_a_controls = s.eff[0]; // RULE_18
  assign lane_b_controls = s.eff[1]; // RULE_18
  assign lane_a_multi_out_pin = s.mf[0];
  assign lane_b_multi_out_pin = s.mf[1];

  // One interface and combining module per channel.
  lcc_lane_if lane [0:1] ();

  // Each channel is combined alone from its own register.
  for (genvar g = 0; g < 2; g++) begin : g_lane
    // Feed raw fields and shared terms.
    assign lane[g].raw = s.chan[g][11:0]; // RULE_16
    assign lane[g].glob = global_cfg;
    // Only the second synchroniser stage is read.
    assign lane[g].comma_pin = s.sync2[SYN_COMMA];
    assign lane[g].ctrl_loop = ctrl_loopback;
    assign lane[g].ctrl_pdown = ctrl_power_down;
    // Combining logic.
    lcc_lane_mix u_mix (
      .bus(lane[g])
    );
    // Collect the result.
    assign mix_eff[g] = lane[g].eff;
  end

  // Next-state logic for synchronisers, registers, reads and pins.
  always_comb begin
    next_s = s;
    // Two-stage synchroniser; stage one feeds only stage two.
    next_s.sync1 = pin_raw;
    next_s.sync2 = s.sync1;
    // Effective controls are registered one cycle after their inputs.
    next_s.eff = mix_eff; // RULE_18
    for (int g = 0; g < 2; g++) begin
      // Start from all software bits, reserved bits never change.
      wmask[g] = WRITE_MASK; // RULE_01
      // Setup bits freeze while their pins are high.
      wmask[g][B_SETUP_HI] = ~s.sync2[SYN_SETUP_HI]; // RULE_08
      wmask[g][B_SETUP_LO] = ~s.sync2[SYN_SETUP_LO]; // RULE_09
      // Pattern test bit freezes while its pin is high.
      wmask[g][B_PRBS] = ~s.sync2[SYN_PATTERN]; // RULE_13
      // Only channel A loopback has a locking pin.
      if (g == 0) begin
        wmask[g][B_LOOP] = ~s.sync2[SYN_LOOP_A]; // RULE_12
      end
      // Commit a write to the addressed channel only.
      if (access_write && hit[g]) begin
        next_s.chan[g] = (s.chan[g] & ~wmask[g]) | (pwdata[15:0] & wmask[g]); // RULE_16
      end
      // A global write lands last and overrides the copied fields.
      if (global_write) begin
        next_s.chan[g] = (next_s.chan[g] & ~GLOBAL_COPY_MASK) | (global_cfg & GLOBAL_COPY_MASK); // RULE_17
      end
      // Pin source follows the effective selector.
      case (s.eff[g][B_MF_HI:B_MF_LO]) // RULE_03 RULE_18
        MF_IO_STD: begin
          // High means HSTL, low means SSTL.
          next_s.mf[g] = s.sync2[SYN_IO_STD];
        end
        MF_COMMA: begin
          // High means comma seen, low means data.
          next_s.mf[g] = comma_detected[g];
        end
        MF_MISSING: begin
          // Signal-missing status of this channel.
          next_s.mf[g] = status_22[ST_MISSING_BASE + g]; // RULE_04 RULE_05
        end
        MF_PATTERN: begin
          // Pattern pass status of this channel.
          next_s.mf[g] = status_22[ST_PATTERN_BASE + g]; // RULE_04 RULE_05
        end
        default: begin
          // Not reachable with two bits; keeps the pin defined.
          next_s.mf[g] = 1'b0;
        end
      endcase
    end
    // Read data is captured in the setup cycle.
    if (setup_phase) begin
      if (hit[0]) begin
        next_s.rdata = s.chan[0] & WRITE_MASK; // RULE_01
      end else if (hit[1]) begin
        next_s.rdata = s.chan[1] & WRITE_MASK; // RULE_01
      end else begin
        // Unmapped reads return zero.
        next_s.rdata = 16'h0000;
      end
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '0;
      s.chan[0] <= CHAN_RESET;
      s.chan[1] <= CHAN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Checks run on the system clock and pause in reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Reserved bits stay zero in both channels.
  chk_reserved_zero: assert property ( // RULE_01
    s.chan[0][15:12] == 4'h0 && s.chan[1][15:12] == 4'h0
  ) else $error("reserved channel bits not zero");

  // Compensation enable follows the OR one cycle later.
  chk_ctc_or: assert property ( // RULE_02
    resetn |=> lane_a_controls[B_CTC] == $past(s.chan[0][B_CTC] | global_cfg[B_CTC])
  ) else $error("compensation enable not ORed");

  // Selector is the bitwise OR of both fields.
  chk_sel_or: assert property ( // RULE_06
    resetn |=> lane_b_controls[B_MF_HI:B_MF_LO] ==
      $past(s.chan[1][B_MF_HI:B_MF_LO] | global_cfg[B_MF_HI:B_MF_LO])
  ) else $error("pin selector not ORed");

  // Signal-missing detect needs both enables.
  chk_los_and: assert property ( // RULE_07
    resetn |=> lane_b_controls[B_LOS] == $past(s.chan[1][B_LOS] & global_cfg[B_LOS])
  ) else $error("signal missing enable not ANDed");

  // Comma detect needs register, global bit and pin.
  chk_comma_and: assert property ( // RULE_14
    resetn |=> lane_a_controls[B_COMMA] ==
      $past(s.chan[0][B_COMMA] & global_cfg[B_COMMA] & s.sync2[SYN_COMMA])
  ) else $error("comma enable not ANDed");

  // Power-down joins control bit 11.
  chk_pdown_or: assert property ( // RULE_15
    resetn |=> lane_b_controls[B_PDOWN] == $past(s.chan[1][B_PDOWN] | ctrl_power_down)
  ) else $error("power down not ORed");

  // Loopback joins control bit 14.
  chk_loop_or: assert property ( // RULE_11
    resetn |=> lane_a_controls[B_LOOP] == $past(s.chan[0][B_LOOP] | ctrl_loopback)
  ) else $error("loopback not ORed");

  // A high pattern pin freezes the pattern bit.
  chk_pattern_lock: assert property ( // RULE_13
    s.sync2[SYN_PATTERN] && !global_write |=> $stable(s.chan[1][B_PRBS])
  ) else $error("pattern bit changed while locked");

  // A high loopback pin freezes channel A loopback.
  chk_loop_lock: assert property ( // RULE_12
    s.sync2[SYN_LOOP_A] |=> $stable(s.chan[0][B_LOOP])
  ) else $error("loopback bit changed while locked");

  // The high setup bit of channel A freezes while its pin is high.
  chk_setup_lock: assert property ( // RULE_08
    s.sync2[SYN_SETUP_HI] && !global_write |=> $stable(s.chan[0][B_SETUP_HI])
  ) else $error("setup bit changed while locked");

  // Channel A signal-missing selection shows status bit 0.
  chk_mf_a_los: assert property ( // RULE_04
    s.eff[0][B_MF_HI:B_MF_LO] == MF_MISSING |=> lane_a_multi_out_pin == $past(status_22[0])
  ) else $error("channel A pin not showing status bit 0");

  // Channel B pattern selection shows status bit 5.
  chk_mf_b_prbs: assert property ( // RULE_05
    s.eff[1][B_MF_HI:B_MF_LO] == MF_PATTERN |=> lane_b_multi_out_pin == $past(status_22[5])
  ) else $error("channel B pin not showing status bit 5");

  // Global write copies its fields into both channels.
  chk_global_copy: assert property ( // RULE_17
    global_write |=> s.chan[0][11:4] == $past(global_cfg[11:4]) &&
      s.chan[1][11:4] == $past(global_cfg[11:4])
  ) else $error("global write did not overwrite channels");

  // A write to channel B leaves channel A alone.
  chk_b_isolated: assert property ( // RULE_16
    access_write && hit[1] && !global_write |=> $stable(s.chan[0])
  ) else $error("channel B write disturbed channel A");

  // Emphasis bits join the global bits by a plain OR.
  chk_emph_or: assert property ( // RULE_10
    resetn |=> lane_a_controls[B_EMPH_HI:B_EMPH_LO] ==
      $past(s.chan[0][B_EMPH_HI:B_EMPH_LO] | global_cfg[B_EMPH_HI:B_EMPH_LO])
  ) else $error("emphasis bits not ORed");

  // Channel B compensation enable is ORed on its own.
  chk_ctc_b_or: assert property ( // RULE_02
    resetn |=> lane_b_controls[B_CTC] == $past(s.chan[1][B_CTC] | global_cfg[B_CTC])
  ) else $error("channel B compensation enable not ORed");

  // The low setup bit freezes while its pin is high.
  chk_setup_lo_lock: assert property ( // RULE_09
    s.sync2[SYN_SETUP_LO] && !global_write |=> $stable(s.chan[1][B_SETUP_LO])
  ) else $error("low setup bit changed while locked");

  // The pattern pin also freezes channel A.
  chk_pattern_lock_a: assert property ( // RULE_13
    s.sync2[SYN_PATTERN] && !global_write |=> $stable(s.chan[0][B_PRBS])
  ) else $error("channel A pattern bit changed while locked");

  // Channel A pattern selection shows status bit 4.
  chk_mf_a_prbs: assert property ( // RULE_04
    s.eff[0][B_MF_HI:B_MF_LO] == MF_PATTERN |=> lane_a_multi_out_pin == $past(status_22[4])
  ) else $error("channel A pin not showing status bit 4");

  // Channel B signal-missing selection shows status bit 1.
  chk_mf_b_los: assert property ( // RULE_05
    s.eff[1][B_MF_HI:B_MF_LO] == MF_MISSING |=> lane_b_multi_out_pin == $past(status_22[1])
  ) else $error("channel B pin not showing status bit 1");

  // Default selection shows the synchronised standard pin.
  chk_mf_io_std: assert property ( // RULE_03
    s.eff[0][B_MF_HI:B_MF_LO] == MF_IO_STD |=> lane_a_multi_out_pin == $past(s.sync2[SYN_IO_STD])
  ) else $error("channel A pin not showing the standard level");

  // Comma selection shows the channel's own comma flag.
  chk_mf_comma: assert property ( // RULE_03
    s.eff[1][B_MF_HI:B_MF_LO] == MF_COMMA |=> lane_b_multi_out_pin == $past(comma_detected[1])
  ) else $error("channel B pin not showing comma flag");

  // Read data never carries reserved or upper bits.
  chk_read_top_zero: assert property ( // RULE_01
    prdata[31:12] == 20'h00000
  ) else $error("reserved read bits not zero");

  // Unlocked emphasis bits take the written value.
  chk_write_lands: assert property ( // RULE_10
    access_write && hit[0] && !global_write |=> s.chan[0][B_EMPH_HI:B_EMPH_LO] ==
      $past(pwdata[B_EMPH_HI:B_EMPH_LO])
  ) else $error("channel A write did not land");

  // A write to channel A leaves channel B alone.
  chk_a_isolated: assert property ( // RULE_16
    access_write && hit[0] && !global_write |=> $stable(s.chan[1])
  ) else $error("channel A write disturbed channel B");

endmodule

`default_nettype wire

/* logic/lcc_pkg.sv */
// Purpose: Shared constants of the lane channel configuration register bank.
// Assumes: Registers are reached over APB with 32-bit data and word addresses.
// Notes: Bit positions of the effective controls match the register fields.
`default_nettype none

package lcc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CHAN_A = 10'h011;
  localparam logic [9:0] IDX_CHAN_B = 10'h012;
  localparam logic [11:0] ADDR_CHAN_A = 12'h044;
  localparam logic [11:0] ADDR_CHAN_B = 12'h048;

  // Field positions inside a channel register.
  localparam int B_PDOWN = 0;
  localparam int B_COMMA = 1;
  localparam int B_PRBS = 2;
  localparam int B_LOOP = 3;
  localparam int B_EMPH_LO = 4;
  localparam int B_EMPH_HI = 5;
  localparam int B_SETUP_LO = 6;
  localparam int B_SETUP_HI = 7;
  localparam int B_LOS = 8;
  localparam int B_MF_LO = 9;
  localparam int B_MF_HI = 10;
  localparam int B_CTC = 11;

  // Value after reset: signal-missing detect and comma detect enabled.
  localparam logic [15:0] CHAN_RESET = 16'h0102;
  // Bits that software may write at all; 15:12 are reserved.
  localparam logic [15:0] WRITE_MASK = 16'h0fff;
  // Fields that a global configuration write copies into each channel.
  localparam logic [15:0] GLOBAL_COPY_MASK = 16'h0ff6;
  // Fields combined with the global register by a plain OR.
  localparam logic [11:0] OR_GLOBAL_MASK = 12'hef4;

  // Multifunction pin selector codes.
  localparam logic [1:0] MF_IO_STD = 2'h0;
  localparam logic [1:0] MF_COMMA = 2'h1;
  localparam logic [1:0] MF_MISSING = 2'h2;
  localparam logic [1:0] MF_PATTERN = 2'h3;

  // Status register 22 bit of channel A; channel B follows at plus one.
  localparam int ST_MISSING_BASE = 0;
  localparam int ST_PATTERN_BASE = 4;

  // Positions of the pins inside the synchroniser vectors.
  localparam int SYN_LOOP_A = 0;
  localparam int SYN_PATTERN = 1;
  localparam int SYN_COMMA = 2;
  localparam int SYN_SETUP_LO = 3;
  localparam int SYN_SETUP_HI = 4;
  localparam int SYN_IO_STD = 5;
  localparam int SYN_WIDTH = 6;

endpackage

`default_nettype wire

/* logic/lcc_lane_if.sv */
// Purpose: Carries one channel's raw fields and effective controls.
// Assumes: Driven by the register bank and the combining module.
// Notes: All signals are levels on the system clock.
`timescale 1ns/1ps
`default_nettype none

interface lcc_lane_if;
  // Raw channel register fields 11:0.
  logic [11:0] raw;
  // Global configuration register contents.
  logic [15:0] glob;
  // Synchronised comma align pin level.
  logic comma_pin;
  // Control register 0 loopback bit.
  logic ctrl_loop;
  // Control register 0 power-down bit.
  logic ctrl_pdown;
  // Effective controls, same bit positions as the register.
  logic [11:0] eff;

  // Combining side.
  modport mix (input raw, input glob, input comma_pin, input ctrl_loop, input ctrl_pdown, output eff);
  // Register bank side.
  modport regs (output raw, output glob, output comma_pin, output ctrl_loop, output ctrl_pdown, input eff);
endinterface

`default_nettype wire

/* logic/lcc_lane_mix.sv */
// Purpose: Forms one channel's effective controls from its raw fields.
// Assumes: Inputs are stable levels on the system clock.
// Notes: Purely combinational; the register bank registers the result.
`timescale 1ns/1ps
`default_nettype none

module lcc_lane_mix
  import lcc_pkg::*;
(
  // Channel connection.
  lcc_lane_if.mix bus
);

  // OR-combined fields first, then the fields with their own terms.
  always_comb begin
    bus.eff = (bus.raw | bus.glob[11:0]) & OR_GLOBAL_MASK; // RULE_02 RULE_06 RULE_08 RULE_09 RULE_10 RULE_13
    // Signal-missing detect runs only when both enables agree.
    bus.eff[B_LOS] = bus.raw[B_LOS] & bus.glob[B_LOS]; // RULE_07
    // Comma detect also needs the align pin.
    bus.eff[B_COMMA] = bus.raw[B_COMMA] & bus.glob[B_COMMA] & bus.comma_pin; // RULE_14
    // Loopback joins the control register bit.
    bus.eff[B_LOOP] = bus.raw[B_LOOP] | bus.ctrl_loop; // RULE_11
    // Power-down joins the control register bit.
    bus.eff[B_PDOWN] = bus.raw[B_PDOWN] | bus.ctrl_pdown; // RULE_15
  end

endmodule

`default_nettype wire

/* tb/lcc_host.sv */
// Purpose: Management host model that reaches the channel registers over APB.
// Assumes: Single system clock; the slave answers whenever pready is seen high.
// Notes: A wait longer than sixteen access cycles is reported as a hang.
`timescale 1ns/1ps
`default_nettype none

module lcc_host (
  // Clock.
  input wire logic clk_sys,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus is idle from time zero so no transfer is seen during reset.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One whole transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    hung = 1'b1;
    rd = 32'h0;
    err = 1'b0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16 && hung; n++) begin
      @(posedge clk_sys);
      // Data and response are taken only at the edge that completes the access.
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        hung = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* tb/lane_channel_config_regs_test.sv */
// Purpose: Self-checking bench for the channel A and B configuration registers.
// Assumes: Pins pass a two-flop synchroniser; controls lag the register by one cycle.
// Notes: Every scenario drives the block and judges the result before returning.
`timescale 1ns/1ps
`default_nettype none

module lane_channel_config_regs_test;
  import lcc_pkg::*;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, global_write;
  logic [11:0] paddr, lane_a_controls, lane_b_controls;
  logic [31:0] pwdata, prdata;
  logic [15:0] global_cfg;
  logic [7:0] status_22;
  logic [1:0] comma_detected;
  logic ctrl_loopback, ctrl_power_down, lane_a_loopback_pin, pattern_test_pin, comma_align_pin;
  logic setup_select_low_pin, setup_select_high_pin, io_standard_pin, mf_a, mf_b;
  int num_errors = 0;
  int comparisons = 0;

  lcc_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_cfg(global_cfg), .global_write(global_write),
    .ctrl_loopback(ctrl_loopback), .ctrl_power_down(ctrl_power_down), .status_22(status_22),
    .comma_detected(comma_detected), .lane_a_loopback_pin(lane_a_loopback_pin),
    .pattern_test_pin(pattern_test_pin), .comma_align_pin(comma_align_pin),
    .setup_select_low_pin(setup_select_low_pin), .setup_select_high_pin(setup_select_high_pin),
    .io_standard_pin(io_standard_pin), .lane_a_multi_out_pin(mf_a), .lane_b_multi_out_pin(mf_b),
    .lane_a_controls(lane_a_controls), .lane_b_controls(lane_b_controls));
  lcc_host i_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running 50 ns system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compares a bus word or a control vector.
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one output pin.
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits n edges, then lets their updates settle.
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bus access; a hung slave ends the run as a failure.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    logic hung;
    i_host.xfer(wr, a, wd, rd, err, hung);
    if (hung) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    bus(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    bus(1'b0, a, 32'h0, rd, err);
    check_word(rd, exp);
  endtask

  // Effective controls worked out from the combining rules.
  function automatic logic [11:0] exp_eff(logic [11:0] r, logic [15:0] g, logic pin, logic lp, logic pd);
    exp_eff = r | (g[11:0] & 12'hef4);
    exp_eff[8] = r[8] & g[8];
    exp_eff[1] = r[1] & g[1] & pin;
    exp_eff[3] = r[3] | lp;
    exp_eff[0] = r[0] | pd;
  endfunction

  // Reset values, then reserved bits on a full write.
  task automatic test_reset();
    hold(3);
    check_word({20'h0, lane_a_controls}, 32'h102);
    rd_chk(ADDR_CHAN_A, 32'h0102);
    rd_chk(ADDR_CHAN_B, 32'h0102);
    wr(ADDR_CHAN_A, 32'hffff_ffff);
    rd_chk(ADDR_CHAN_A, 32'h0fff);
    $display("test reset done");
  endtask

  // Channel fields against the global register, control bits and sync pin.
  task automatic test_combine();
    logic [11:0] rv[3] = '{12'h5a5, 12'hfff, 12'h30a};
    logic [15:0] gv[3] = '{16'h0000, 16'h0f0f, 16'hf1f2};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CHAN_A, {20'h0, rv[i]});
      wr(ADDR_CHAN_B, {20'h0, ~rv[i]});
      global_cfg <= gv[i];
      ctrl_loopback <= i[0];
      ctrl_power_down <= i[1];
      comma_align_pin <= ~i[0];
      hold(5);
      check_word({20'h0, lane_a_controls}, {20'h0, exp_eff(rv[i], gv[i], ~i[0], i[0], i[1])});
      check_word({20'h0, lane_b_controls}, {20'h0, exp_eff(~rv[i], gv[i], ~i[0], i[0], i[1])});
    end
    $display("test combine done");
  endtask

  // Pin locks on bits 7, 6, 2 and channel A bit 3.
  task automatic test_lock();
    wr(ADDR_CHAN_A, 32'h0fff);
    wr(ADDR_CHAN_B, 32'h0fff);
    {setup_select_high_pin, setup_select_low_pin, pattern_test_pin, lane_a_loopback_pin} <= 4'hf;
    hold(4);
    wr(ADDR_CHAN_A, 32'h0);
    wr(ADDR_CHAN_B, 32'h0);
    rd_chk(ADDR_CHAN_A, 32'h00cc);
    rd_chk(ADDR_CHAN_B, 32'h00c4);
    {setup_select_high_pin, setup_select_low_pin, pattern_test_pin, lane_a_loopback_pin} <= 4'h0;
    hold(4);
    wr(ADDR_CHAN_A, 32'h0009);
    rd_chk(ADDR_CHAN_A, 32'h0009);
    $display("test lock done");
  endtask

  // A global write copies its fields but keeps loopback and power-down.
  task automatic test_global();
    @(posedge clk_sys);
    global_cfg <= 16'ha5a5;
    global_write <= 1'b1;
    @(posedge clk_sys);
    global_write <= 1'b0;
    rd_chk(ADDR_CHAN_A, 32'h05ad);
    rd_chk(ADDR_CHAN_B, 32'h05a4);
    $display("test global done");
  endtask

  // Every selector code on both pins, the code split between channel and global.
  task automatic test_pins();
    logic [1:0] s;
    logic v;
    logic [1:0] cd;
    logic [7:0] st;
    for (int k = 0; k < 16; k++) begin
      s = k[2:1];
      v = k[0];
      // Channel supplies selector bit 9, global supplies bit 10.
      wr(k[3] ? ADDR_CHAN_B : ADDR_CHAN_A, {22'h0, s[0], 9'h002});
      global_cfg <= {5'h0, s[1], 10'h102};
      cd = {2{~v}};
      st = {8{~v}};
      if (s == MF_COMMA) cd[k[3]] = v;
      if (s == MF_MISSING) st[k[3]] = v;
      if (s == MF_PATTERN) st[4 + k[3]] = v;
      io_standard_pin <= (s == MF_IO_STD) ? v : ~v;
      comma_detected <= cd;
      status_22 <= st;
      hold(5);
      check_bit(k[3] ? mf_b : mf_a, v);
    end
    $display("test pins done");
  endtask

  // Unmapped address: error response, zero data, no side effect.
  task automatic test_unmapped();
    logic [31:0] rd;
    logic err;
    bus(1'b0, 12'h040, 32'h0, rd, err);
    check_bit(err, 1'b1);
    check_word(rd, 32'h0);
    wr(12'h04c, 32'h0fff);
    rd_chk(ADDR_CHAN_A, 32'h0202);
    $display("test unmapped done");
  endtask

  // Main sequence.
  initial begin
    resetn = 1'b0;
    global_cfg = 16'h0102;
    global_write = 1'b0;
    {ctrl_loopback, ctrl_power_down, lane_a_loopback_pin, pattern_test_pin} = 4'h0;
    {setup_select_low_pin, setup_select_high_pin, io_standard_pin} = 3'h0;
    comma_align_pin = 1'b1;
    status_22 = 8'h00;
    comma_detected = 2'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    test_reset();
    test_combine();
    test_lock();
    test_global();
    test_pins();
    test_unmapped();
    complete_run();
  end
endmodule

`default_nettype wire
